//--- pmt_pkg.sv
// Register map, field layout and timing constants of the period match timer
package pmt_pkg;
  localparam int unsigned PMT_DATA_W = 8;
  localparam int unsigned PMT_NUM_TIMERS = 3;
  // Per-instance register window: base = index * stride
  localparam logic [7:0] PMT_INST_STRIDE = 8'h10;
  localparam logic [3:0] PMT_OFS_COUNT = 4'h0;
  localparam logic [3:0] PMT_OFS_PERIOD = 4'h4;
  localparam logic [3:0] PMT_OFS_CONTROL = 4'h8;
  // Shared interrupt registers
  localparam logic [7:0] PMT_OFS_FLAG = 8'h40;
  localparam logic [7:0] PMT_OFS_ENABLE = 8'h44;
  localparam logic [7:0] PMT_OFS_CLEAR = 8'h48;
  // Control field layout
  localparam int unsigned PMT_PRESCALE_LSB = 0;
  localparam int unsigned PMT_ON_BIT = 2;
  localparam int unsigned PMT_POSTSCALE_LSB = 3;
  localparam logic [7:0] PMT_CONTROL_MASK = 8'h7f;
  // Reset values
  localparam logic [7:0] PMT_COUNT_RESET = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RESET = 8'hff;
  localparam logic [7:0] PMT_CONTROL_RESET = 8'h00;
  // Oscillator cycles per instruction cycle
  localparam int unsigned PMT_INSTR_DIV = 4;
  localparam logic [1:0] PMT_INSTR_LAST = 2'(PMT_INSTR_DIV - 1);
  // Prescale codes
  typedef enum logic [1:0] {
    PMT_PRE_1 = 2'b00,
    PMT_PRE_4 = 2'b01,
    PMT_PRE_16 = 2'b10,
    PMT_PRE_64 = 2'b11
  } pmt_prescale_t;
endpackage

//--- pmt_timer.sv
// Bank of 8-bit period match timers with prescaler, postscaler and APB registers
//
// Summary of operation
// - Up to three identical timers, each with count, period and control.
// - Counting clock is the instruction clock, one quarter of the oscillator.
// - Count steps up by one from zero per prescaled tick while on.
// - Prescale codes 00,01,10,11 divide by 1, 4, 16 and 64.
// - Count is compared with period and a match output is raised.
// - A match clears the count next cycle and steps the postscaler.
// - Count and period registers are readable and writable at any time.
// - Reset clears count and sets period to all ones.
// - Prescaler and postscaler clear on count write, control write, reset.
// - Four-bit postscaler sets the latched match flag at the chosen count.
// - The flag raises the interrupt only while its enable is set.
// - Postscale code plus one matches give one flag setting.
// - Unscaled match feeds capture/PWM units; timer zero also gives shift clock.
// - No counting during sleep; count and period are kept.
`timescale 1ns/100ps
module pmt_timer
  import pmt_pkg::*;
#(
  parameter int unsigned NUM_TIMERS = PMT_NUM_TIMERS
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep,
  output logic [NUM_TIMERS-1:0] match_out,
  output logic shift_clk,
  output logic irq
);

  // Terminal value of the prescaler for a given code
  function automatic logic [5:0] pre_last(input logic [1:0] code);
    case (pmt_prescale_t'(code))
      PMT_PRE_1: pre_last = 6'd0;
      PMT_PRE_4: pre_last = 6'd3;
      PMT_PRE_16: pre_last = 6'd15;
      PMT_PRE_64: pre_last = 6'd63;
      default: pre_last = 6'd0;
    endcase
  endfunction

  logic [7:0] count [NUM_TIMERS];
  logic [7:0] period [NUM_TIMERS];
  logic [7:0] control [NUM_TIMERS];
  logic [5:0] pre [NUM_TIMERS];
  logic [3:0] post [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] flag;
  logic [NUM_TIMERS-1:0] enable;
  logic [1:0] instr_cnt;
  logic instr_tick;

  logic acc;
  logic wr;
  logic inst_hit;
  logic [1:0] inst_sel;
  logic [NUM_TIMERS-1:0] wr_count;
  logic [NUM_TIMERS-1:0] wr_period;
  logic [NUM_TIMERS-1:0] wr_control;
  logic wr_enable;
  logic wr_clear;
  logic [NUM_TIMERS-1:0] run;
  logic [NUM_TIMERS-1:0] adv;
  logic [NUM_TIMERS-1:0] equal;
  logic [NUM_TIMERS-1:0] flag_set;
  logic [NUM_TIMERS-1:0] next_flag;

  // Bus decode
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign inst_sel = paddr[5:4];
  assign inst_hit = !paddr[7] && !paddr[6] && (32'(inst_sel) < NUM_TIMERS);
  assign wr_enable = wr && paddr == PMT_OFS_ENABLE;
  assign wr_clear = wr && paddr == PMT_OFS_CLEAR;

  always_comb
  begin
    for (int i = 0; i < NUM_TIMERS; i++)
    begin
      wr_count[i] = wr && inst_hit && 32'(inst_sel) == i && paddr[3:0] == PMT_OFS_COUNT;
      wr_period[i] = wr && inst_hit && 32'(inst_sel) == i && paddr[3:0] == PMT_OFS_PERIOD;
      wr_control[i] = wr && inst_hit && 32'(inst_sel) == i && paddr[3:0] == PMT_OFS_CONTROL;
      // Sleep freezes the timer without touching its registers
      run[i] = instr_tick && control[i][PMT_ON_BIT] && !sleep;
      adv[i] = run[i] && pre[i] == pre_last(control[i][PMT_PRESCALE_LSB +: 2]);
      equal[i] = count[i] == period[i];
      flag_set[i] = adv[i] && equal[i] && !wr_count[i] &&
                    post[i] == control[i][PMT_POSTSCALE_LSB +: 4];
    end
  end

  // Set wins over a clear arriving in the same cycle
  assign next_flag = (flag & ~(wr_clear ? pwdata[NUM_TIMERS-1:0] : '0)) | flag_set;

  // Instruction clock enable from the oscillator clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr_cnt <= 2'b00;
      instr_tick <= 1'b0;
    end
    else
    begin
      instr_cnt <= instr_cnt + 2'b01;
      instr_tick <= instr_cnt == PMT_INSTR_LAST;
    end
  end

  // Count register: bus write takes priority over counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
        count[i] <= PMT_COUNT_RESET;
    end
    else
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        if (wr_count[i])
          count[i] <= pwdata[7:0];
        else if (adv[i] && equal[i])
          count[i] <= PMT_COUNT_RESET;
        else if (adv[i])
          count[i] <= count[i] + 8'h01;
      end
    end
  end

  // Period and control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        period[i] <= PMT_PERIOD_RESET;
        control[i] <= PMT_CONTROL_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        if (wr_period[i])
          period[i] <= pwdata[7:0];
        if (wr_control[i])
          control[i] <= pwdata[7:0] & PMT_CONTROL_MASK;
      end
    end
  end

  // Prescaler and postscaler counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        pre[i] <= 6'd0;
        post[i] <= 4'd0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
      begin
        if (wr_count[i] || wr_control[i])
        begin
          pre[i] <= 6'd0;
          post[i] <= 4'd0;
        end
        else
        begin
          if (adv[i])
            pre[i] <= 6'd0;
          else if (run[i])
            pre[i] <= pre[i] + 6'd1;
          if (flag_set[i])
            post[i] <= 4'd0;
          else if (adv[i] && equal[i])
            post[i] <= post[i] + 4'd1;
        end
      end
    end
  end

  // Unscaled match outputs, one pulse per period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_out <= '0;
      shift_clk <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < NUM_TIMERS; i++)
        match_out[i] <= adv[i] && equal[i];
      // Only timer zero may clock the serial port; selection lives in that port
      shift_clk <= adv[0] && equal[0];
    end
  end

  // Interrupt flags, enables and request line
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag <= '0;
      enable <= '0;
      irq <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
      if (wr_enable)
        enable <= pwdata[NUM_TIMERS-1:0];
      irq <= |(next_flag & (wr_enable ? pwdata[NUM_TIMERS-1:0] : enable));
    end
  end

  // APB slave: zero wait states, registered answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (psel && !penable)
      begin
        if (inst_hit && paddr[3:0] == PMT_OFS_COUNT)
          prdata <= {24'h00_0000, count[inst_sel]};
        else if (inst_hit && paddr[3:0] == PMT_OFS_PERIOD)
          prdata <= {24'h00_0000, period[inst_sel]};
        else if (inst_hit && paddr[3:0] == PMT_OFS_CONTROL)
          prdata <= {24'h00_0000, control[inst_sel]};
        else if (paddr == PMT_OFS_FLAG)
          prdata <= 32'(flag);
        else if (paddr == PMT_OFS_ENABLE)
          prdata <= 32'(enable);
        else if (paddr == PMT_OFS_CLEAR)
          prdata <= 32'h0000_0000;
        else
          pslverr <= 1'b1;
      end
    end
  end

  a_instr_rate: assert property (@(posedge pclk) disable iff (!presetn)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not one in four");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(flag & enable))
    else $error("interrupt line disagrees with enabled flags");

  // Register bus answers in the cycle after setup, never while idle
  a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("no ready in access phase");

  a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable) |=> !pready)
    else $error("ready without a setup cycle");

  a_error_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error response outside access phase");

  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read data bits not zero");

  for (genvar k = 0; k < NUM_TIMERS; k++)
  begin : g_chk
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
      adv[k] && !equal[k] && !wr_count[k] |=> count[k] == $past(count[k]) + 8'h01)
      else $error("count did not step by one");

    a_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
      adv[k] && equal[k] && !wr_count[k] |=> count[k] == 8'h00 && match_out[k])
      else $error("match did not clear count");

    a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!control[k][PMT_ON_BIT] || sleep) && !wr_count[k] |=> $stable(count[k]))
      else $error("count moved while stopped");

    a_prescale_gap: assert property (@(posedge pclk) disable iff (!presetn)
      adv[k] && control[k][1:0] == 2'b01 && !wr_count[k] && !wr_control[k] |=> !adv[k] [*8])
      else $error("divide by four ticked too soon");

    a_scaler_clear: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count[k] || wr_control[k] |=> pre[k] == 6'd0 && post[k] == 4'd0)
      else $error("scalers not cleared by write");

    a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      flag_set[k] |=> flag[k])
      else $error("postscaled match lost");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      flag[k] && !(wr_clear && pwdata[k]) |=> flag[k])
      else $error("flag dropped without clear");

    a_count_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count[k] |=> count[k] == $past(pwdata[7:0]))
      else $error("count write lost");

    a_period_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_period[k] |=> period[k] == $past(pwdata[7:0]))
      else $error("period write lost");

    a_period_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_period[k] |=> $stable(period[k]))
      else $error("period changed without a write");

    a_match_only: assert property (@(posedge pclk) disable iff (!presetn)
      !(adv[k] && equal[k]) |=> !match_out[k])
      else $error("match output without a match");

    a_match_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      match_out[k] |=> !match_out[k])
      else $error("match output longer than one cycle");

    a_pre_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !run[k] && !wr_count[k] && !wr_control[k] |=> $stable(pre[k]))
      else $error("prescaler moved while stopped");

    a_post_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(adv[k] && equal[k]) && !wr_count[k] && !wr_control[k] |=> $stable(post[k]))
      else $error("postscaler moved without a match");

    a_flag_source: assert property (@(posedge pclk) disable iff (!presetn)
      !flag[k] && !flag_set[k] |=> !flag[k])
      else $error("flag set without postscaled match");

    a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
      wr_clear && pwdata[k] && !flag_set[k] |=> !flag[k])
      else $error("flag not cleared by software");

    a_control_mask: assert property (@(posedge pclk) disable iff (!presetn)
      control[k][7] == 1'b0)
      else $error("unused control bit set");

    // Reset values, seen at the first edge after release
    a_reset_regs: assert property (@(posedge pclk)
      $rose(presetn) |-> count[k] == PMT_COUNT_RESET && period[k] == PMT_PERIOD_RESET)
      else $error("count or period wrong after reset");

    a_reset_scalers: assert property (@(posedge pclk)
      $rose(presetn) |-> pre[k] == 6'd0 && post[k] == 4'd0)
      else $error("scalers not cleared by reset");
  end

endmodule

//--- pmt_timer_tb_top.sv
// Self-checking testbench of the period match timer bank
`timescale 1ns/100ps
module pmt_timer_tb_top;
  import pmt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sleep;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, shift_clk, irq;
  logic [2:0] match_out;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  pmt_timer u_pmt_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .match_out(match_out), .shift_clk(shift_clk), .irq(irq));
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task finish_test();
    $display("Counts: %0d checks, %0d errors", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Whole run needs about 4k cycles
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end
  task check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task check_cnt(input int got, input int exp);
    checks++;
    if (got != exp)
    begin
      num_errors++;
      $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    check_val(rd, exp);
  endtask
  // Edges until the next unscaled match pulse of one timer
  task wait_match(input int i, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (match_out[i] !== 1'b1 && n < 6000);
    check_val({31'h0, match_out[i]}, 32'h0000_0001);
    check_val({31'h0, shift_clk}, {31'h0, i == 0});
  endtask
  task test_regs();
    logic [31:0] rd;
    logic err;
    for (int i = 0; i < 3; i++)
    begin
      rd_chk(8'(16 * i) + 8'h00, 32'h0000_0000);
      rd_chk(8'(16 * i) + 8'h04, 32'h0000_00ff);
      rd_chk(8'(16 * i) + 8'h08, 32'h0000_0000);
      wr(8'(16 * i) + 8'h00, 32'h0000_0033);
      rd_chk(8'(16 * i) + 8'h00, 32'h0000_0033);
      wr(8'(16 * i) + 8'h04, 32'h0000_005a);
      rd_chk(8'(16 * i) + 8'h04, 32'h0000_005a);
    end
    wr(8'h08, 32'h0000_00fb);
    rd_chk(8'h08, 32'h0000_007b);
    wr(8'h08, 32'h0000_0000);
    apb(1'b0, 8'h50, 32'h0000_0000, rd, err);
    check_val({31'h0, err}, 32'h0000_0001);
    $display("test_regs done");
  endtask
  task test_prescale();
    int n;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'(16 * (c % 3)) + 8'h04, 32'(c + 1));
      // A count left above the period would wrap through 255 first
      wr(8'(16 * (c % 3)) + 8'h00, 32'h0000_0000);
      wr(8'(16 * (c % 3)) + 8'h08, 32'h0000_0004 | 32'(c));
      wait_match(c % 3, n);
      wait_match(c % 3, n);
      check_cnt(n, (c + 2) * 4 * (1 << (2 * c)));
      wr(8'(16 * (c % 3)) + 8'h08, 32'h0000_0000);
    end
    $display("test_prescale done");
  endtask
  task test_postscale();
    int n;
    int codes [3];
    codes = '{0, 3, 15};
    foreach (codes[j])
    begin
      // Stop and rewind first so no match slips in before the flag is cleared
      wr(8'h08, 32'h0000_0000);
      wr(8'h00, 32'h0000_0000);
      wr(8'h04, 32'h0000_0001);
      wr(8'h48, 32'h0000_0007);
      wr(8'h08, 32'h0000_0004 | 32'(codes[j] << 3));
      for (int k = 1; k <= codes[j] + 1; k++)
      begin
        wait_match(0, n);
        rd_chk(8'h40, {31'h0, k == codes[j] + 1});
      end
    end
    wr(8'h40, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0001);
    wr(8'h44, 32'h0000_0001);
    @(posedge pclk);
    check_val({31'h0, irq}, 32'h0000_0001);
    wr(8'h44, 32'h0000_0000);
    @(posedge pclk);
    check_val({31'h0, irq}, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    wr(8'h48, 32'h0000_0001);
    rd_chk(8'h40, 32'h0000_0000);
    $display("test_postscale done");
  endtask
  task test_sleep();
    wr(8'h04, 32'h0000_00ff);
    wr(8'h00, 32'h0000_0010);
    sleep <= 1'b1;
    wr(8'h08, 32'h0000_0004);
    repeat (40) @(posedge pclk);
    rd_chk(8'h00, 32'h0000_0010);
    rd_chk(8'h04, 32'h0000_00ff);
    sleep <= 1'b0;
    // 38 idle edges plus the two edges of the stopping write: exactly ten ticks in any phase
    repeat (38) @(posedge pclk);
    wr(8'h08, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_001a);
    $display("test_sleep done");
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sleep = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_regs();
    test_prescale();
    test_postscale();
    test_sleep();
    finish_test();
  end
endmodule
